// ===== remappable_output_pin_select_tb.sv
// Self-checking bench for the remappable output pin select
`timescale 1ns/10ps
`default_nettype none
module remappable_output_pin_select_tb;
  // Table of codes: bit set where the code routes a peripheral
  localparam logic [63:0] ROUTED = 64'hf8ff_fffc_1bbf_fffe;
  localparam logic [1:0] OK = rpsel_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = rpsel_pkg::RESP_SLVERR;
  localparam logic [7:0] CTRL = rpsel_pkg::ADDR_PORT_CTRL;
  localparam logic [7:0] STAT = rpsel_pkg::ADDR_PORT_STATUS;
  logic        mclk = 1'b0, rst = 1'b1, lazy = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, sel;
  logic [63:0] src = 64'h0;
  logic [1:0]  ded_en = 2'h0, ded = 2'h0, hi_en = 2'h0;
  wire logic   awr, wrdy, bv, arr, rv;
  wire logic [1:0]  bresp, rresp, pin, pin_oe, digin, pad;
  wire logic [31:0] rdata;
  wire logic [5:0]  vrp;
  int          n_mismatch = 0, checked = 0, cyc = 0;

  rpsel_top i_rpsel_top (
    .mclk_i(mclk), .rst_i(rst),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .uart_tx_i({src[27], src[3], src[1]}),
    .uart_rts_i({src[28], src[4], src[2]}), .uart_dtr_i(src[63:61]),
    .spi_sdo_i({src[11], src[8], src[5]}),
    .spi_sck_i({src[12], src[9], src[6]}),
    .spi_ss_i({src[13], src[10], src[7]}), .reference_clock_out_i(src[14]),
    .single_capture_compare_i({src[43:42], src[20:15]}),
    .can_tx_i(src[21]), .comparator_i(src[25:23]),
    .pwm4_high_i(src[34]), .pwm4_low_i(src[35]),
    .pwm_event_i({src[45:44], src[37:36]}),
    .quadrature_encoder_cmp_i(src[39:38]),
    .configurable_logic_cell_i({src[60:59], src[41:40]}),
    .peripheral_trigger_i(src[47:46]), .single_edge_nibble_i(src[49:48]),
    .multi_capture_compare_i(src[55:50]),
    .ded_out_en_i(ded_en), .ded_out_i(ded), .ded_hi_en_i(hi_en),
    .pin_i(pad), .pin_o(pin), .pin_oe_o(pin_oe), .pin_digin_en_o(digin),
    .virtual_route_point_o(vrp)
  );
  rpsel_pad_model i_rpsel_pad_model (
    .drive_i(pin), .drive_en_i(pin_oe), .level_o(pad)
  );

  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ap, dp, ta, td;
    ap = 1'b1;
    dp = 1'b1;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= !lazy;
    while (ap || dp) begin
      @(negedge mclk);
      ta = ap && awr;
      td = dp && wrdy;
      @(posedge mclk);
      if (ta) awv <= 1'b0;
      if (td) wv <= 1'b0;
      ap = ap && !ta;
      dp = dp && !td;
    end
    do @(negedge mclk); while (!bv);
    check(bresp, er);
    @(posedge mclk);
    if (lazy) begin
      bready <= 1'b1;
      @(posedge mclk);
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic t;
    @(posedge mclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= !lazy;
    do begin
      @(negedge mclk);
      t = arr;
      @(posedge mclk);
    end while (!t);
    arv <= 1'b0;
    do @(negedge mclk); while (!rv);
    check(rdata, ed);
    check(rresp, er);
    @(posedge mclk);
    if (lazy) begin
      rready <= 1'b1;
      @(posedge mclk);
    end
    rready <= 1'b0;
  endtask : rd

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check(digin, 2'h0);
    check(vrp, 6'h0);
    lazy = 1'b1;
    for (int a = 0; a < 16; a += 4) rd(a[7:0], 32'h0, OK);
    rd(CTRL, 32'h0000_0303, OK);
    rd(STAT, 32'h0, OK);
    rd(8'h20, 32'h0, ERR);
    wr(STAT, 32'h1, ERR);
    wr(rpsel_pkg::ADDR_VIRT_OUT_SEL_24, 32'hffff_ffff, OK);
    lazy = 1'b0;
    rd(rpsel_pkg::ADDR_VIRT_OUT_SEL_24, 32'h0000_3f3f, OK);
    wr(CTRL, 32'h0001_0300, OK);
    rd(STAT, 32'h0000_0103, OK);
    check(digin, 2'h3);
    // Every selector code on both pins and all virtual points
    for (int c = 0; c < 64; c++) begin
      sel = {18'h0, c[5:0], 2'h0, c[5:0]};
      for (int r = 0; r < 16; r += 4) wr(r[7:0], sel, OK);
      for (int v = 0; v < 2; v++) begin
        @(posedge mclk);
        src <= v[0] ? ~(64'h1 << c) : 64'h1 << c;
        @(posedge mclk);
        @(negedge mclk);
        if (ROUTED[c]) begin
          check(pin, {2{~v[0]}});
          check(vrp, {6{~v[0]}});
        end else begin
          check(vrp, 6'h0);
          check(pin, 2'h1);
        end
        check(pin_oe, {2{ROUTED[c]}});
      end
    end
    @(posedge mclk);
    src <= 64'h0;
    ded_en <= 2'h3;
    ded <= 2'h1;
    @(posedge mclk);
    @(negedge mclk);
    check(pin, 2'h1);
    check(pin_oe, 2'h3);
    @(posedge mclk);
    hi_en <= 2'h1;
    @(posedge mclk);
    @(negedge mclk);
    check(pin_oe, 2'h2);
    @(posedge mclk);
    ded_en <= 2'h0;
    hi_en <= 2'h0;
    wr(rpsel_pkg::ADDR_PIN_OUT_SEL_23, 32'h0, OK);
    wr(CTRL, 32'h0002_0000, OK);
    rd(STAT, 32'h0003_0202, OK);
    wrap_up();
  end
endmodule : remappable_output_pin_select_tb
`default_nettype wire

// ===== rpsel_pad_model.sv
// Pad model: port pin buffers with weak pull-ups
`timescale 1ns/10ps
`default_nettype none
module rpsel_pad_model #(
  parameter int NPHYS = 2
) (
  // Design side of the pads
  input  wire logic [NPHYS-1:0] drive_i,
  input  wire logic [NPHYS-1:0] drive_en_i,
  // Resolved pad level
  output logic [NPHYS-1:0]      level_o
);
  // Undriven pads float high through the pull-up
  always_comb begin
    for (int k = 0; k < NPHYS; k++) begin
      level_o[k] = drive_en_i[k] ? drive_i[k] : 1'b1;
    end
  end
endmodule : rpsel_pad_model
`default_nettype wire

// ===== rpsel_pkg.sv
// Constants for the remappable output pin select block
package rpsel_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_PIN_OUT_SEL_23  = 8'h00;
  localparam logic [7:0] ADDR_VIRT_OUT_SEL_24 = 8'h04;
  localparam logic [7:0] ADDR_VIRT_OUT_SEL_25 = 8'h08;
  localparam logic [7:0] ADDR_VIRT_OUT_SEL_26 = 8'h0c;
  localparam logic [7:0] ADDR_PORT_CTRL       = 8'h10;
  localparam logic [7:0] ADDR_PORT_STATUS     = 8'h14;

  // Selector field layout inside an output mapping register
  localparam int SEL_W      = 6;
  localparam int SEL_LO_POS = 0;
  localparam int SEL_HI_POS = 8;
  localparam logic [5:0] SEL_RESET = 6'h00;

  // Port control and status field positions
  localparam int ANSEL_POS  = 0;
  localparam int DIR_POS    = 8;
  localparam int LAT_POS    = 16;
  localparam int LEVEL_POS  = 0;
  localparam int LATRD_POS  = 8;
  localparam int OE_POS     = 16;
  localparam int VIRT_POS   = 24;
  localparam logic [1:0] ANSEL_RESET = 2'h3;
  localparam logic [1:0] DIR_RESET   = 2'h3;
  localparam logic [1:0] LAT_RESET   = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Output function selector codes
  localparam logic [5:0] CODE_DEFAULT  = 6'h00;
  localparam logic [5:0] CODE_U1TX     = 6'h01;
  localparam logic [5:0] CODE_U1RTS    = 6'h02;
  localparam logic [5:0] CODE_U2TX     = 6'h03;
  localparam logic [5:0] CODE_U2RTS    = 6'h04;
  localparam logic [5:0] CODE_SPI1     = 6'h05;
  localparam logic [5:0] CODE_SPI2     = 6'h08;
  localparam logic [5:0] CODE_SPI3     = 6'h0b;
  localparam logic [5:0] CODE_REFCLK   = 6'h0e;
  localparam logic [5:0] CODE_SCCP1    = 6'h0f;
  localparam logic [5:0] CODE_CAN      = 6'h15;
  localparam logic [5:0] CODE_CMP1     = 6'h17;
  localparam logic [5:0] CODE_U3TX     = 6'h1b;
  localparam logic [5:0] CODE_U3RTS    = 6'h1c;
  localparam logic [5:0] CODE_PWM4H    = 6'h22;
  localparam logic [5:0] CODE_PWM4L    = 6'h23;
  localparam logic [5:0] CODE_PWM_EVENT_A_OUT    = 6'h24;
  localparam logic [5:0] CODE_QEI1     = 6'h26;
  localparam logic [5:0] CODE_CLC1     = 6'h28;
  localparam logic [5:0] CODE_SCCP7    = 6'h2a;
  localparam logic [5:0] CODE_PWMEC    = 6'h2c;
  localparam logic [5:0] CODE_PTG24    = 6'h2e;
  localparam logic [5:0] CODE_SENT1    = 6'h30;
  localparam logic [5:0] CODE_MULTI_CAPTURE_COMPARE_A   = 6'h32;
  localparam logic [5:0] CODE_CLC3     = 6'h3b;
  localparam logic [5:0] CODE_U1DTR    = 6'h3d;

endpackage : rpsel_pkg

// ===== rpsel_props.sv
// Assertion checker for the remappable output pin select
`timescale 1ns/10ps
`default_nettype none
module rpsel_props #(
  parameter int NPHYS = 2,
  parameter int NVIRT = 6
) (
  // Clock and reset
  input wire logic             mclk_i,
  input wire logic             rst_i,
  // Register bus
  input wire logic             s_axi_awvalid_i,
  input wire logic             s_axi_awready_o,
  input wire logic             s_axi_wvalid_i,
  input wire logic             s_axi_wready_o,
  input wire logic             s_axi_bvalid_o,
  input wire logic             s_axi_bready_i,
  input wire logic [1:0]       s_axi_bresp_o,
  input wire logic             s_axi_arvalid_i,
  input wire logic             s_axi_arready_o,
  input wire logic             s_axi_rvalid_o,
  input wire logic             s_axi_rready_i,
  input wire logic [31:0]      s_axi_rdata_o,
  // Pins
  input wire logic [NPHYS-1:0] ded_out_en_i,
  input wire logic [NPHYS-1:0] ded_out_i,
  input wire logic [NPHYS-1:0] ded_hi_en_i,
  input wire logic [NPHYS-1:0] pin_o,
  input wire logic [NPHYS-1:0] pin_oe_o,
  input wire logic [NPHYS-1:0] pin_digin_en_o,
  input wire logic [NVIRT-1:0] virtual_route_point_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  AST_RST_CLEAR: assert property (disable iff (1'b0)
    rst_i |=> pin_oe_o == '0 && virtual_route_point_o == '0 &&
    pin_digin_en_o == '0) else $error("pins not cleared by reset");
  AST_HI_SUPPRESS: assert property (ded_hi_en_i[0] |=>
    !pin_oe_o[0] && !pin_o[0]) else $error("pin not released");
  AST_DED_WINS: assert property (ded_out_en_i[0] && !ded_hi_en_i[0] |=>
    pin_oe_o[0] && pin_o[0] == $past(ded_out_i[0]))
    else $error("dedicated output lost on pin 0");
  AST_ONE_DRIVER: assert property (ded_out_en_i[1] && !ded_hi_en_i[1] |=>
    pin_oe_o[1] && pin_o[1] == $past(ded_out_i[1]))
    else $error("second driver on pin 1");
  AST_B_LAT: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("response dropped");
  AST_AW_BLOCK: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o && !s_axi_wready_o) else $error("write taken early");
  AST_R_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o) else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
  AST_AR_BLOCK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken early");

  cover property (ded_hi_en_i[0] && ded_out_en_i[0]);
  cover property (s_axi_bvalid_o && s_axi_bresp_o == rpsel_pkg::RESP_SLVERR);
  cover property (virtual_route_point_o == '1);
endmodule : rpsel_props

bind rpsel_top rpsel_props #(.NPHYS(NPHYS), .NVIRT(NVIRT)) i_rpsel_props (
  .mclk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .s_axi_rdata_o, .ded_out_en_i, .ded_out_i, .ded_hi_en_i, .pin_o,
  .pin_oe_o, .pin_digin_en_o, .virtual_route_point_o
);
`default_nettype wire

// ===== rpsel_top.sv
// Remappable output pin select with AXI4-Lite register access
// Function
// - Zero selector keeps default port function
// - Codes route three serial transmit lines
// - Codes route three request-to-send lines
// - First SPI: data, clock, select codes
// - Second, third SPI follow consecutively
// - Reference clock code routes clock out
// - Capture/compare one-six, seven-eight codes
// - CAN code routes transmit output
// - Three comparator codes consecutive
// - PWM four high, low codes
// - PWM event A-B, C-D pairs
// - Encoder comparator outputs two codes
// - Logic cells one-two, three-four pairs
// - Trigger generator outputs 24, 25
// - Nibble transmit modules one, two
// - Multi capture/compare outputs A-F
// - Top three codes route DTR outputs
// - Analog after reset; level and latch reads return zero
// - One output function per pin
// - Dedicated output beats remapped output
// - Higher priority function suppresses lower
// - Active outputs override direction bit
// - Two 6-bit selectors per register
// - Selectors reset to zero
// - Six virtual route points, no pins
`timescale 1ns/10ps
`default_nettype none
module rpsel_top #(
  parameter int NPHYS = 2,
  parameter int NVIRT = 6
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [7:0]        s_axi_awaddr_i,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [7:0]        s_axi_araddr_i,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  // Peripheral outputs
  input  wire logic [2:0]        uart_tx_i,
  input  wire logic [2:0]        uart_rts_i,
  input  wire logic [2:0]        uart_dtr_i,
  input  wire logic [2:0]        spi_sdo_i,
  input  wire logic [2:0]        spi_sck_i,
  input  wire logic [2:0]        spi_ss_i,
  input  wire logic              reference_clock_out_i,
  input  wire logic [7:0]        single_capture_compare_i,
  input  wire logic              can_tx_i,
  input  wire logic [2:0]        comparator_i,
  input  wire logic              pwm4_high_i,
  input  wire logic              pwm4_low_i,
  input  wire logic [3:0]        pwm_event_i,
  input  wire logic [1:0]        quadrature_encoder_cmp_i,
  input  wire logic [3:0]        configurable_logic_cell_i,
  input  wire logic [1:0]        peripheral_trigger_i,
  input  wire logic [1:0]        single_edge_nibble_i,
  input  wire logic [5:0]        multi_capture_compare_i,
  // Dedicated functions per physical pin, ded_hi_en_i beats ded_out_en_i
  input  wire logic [NPHYS-1:0]  ded_out_en_i,
  input  wire logic [NPHYS-1:0]  ded_out_i,
  input  wire logic [NPHYS-1:0]  ded_hi_en_i,
  // Physical pins
  input  wire logic [NPHYS-1:0]  pin_i,
  output logic [NPHYS-1:0]       pin_o,
  output logic [NPHYS-1:0]       pin_oe_o,
  output logic [NPHYS-1:0]       pin_digin_en_o,
  // Virtual route points
  output logic [NVIRT-1:0]       virtual_route_point_o
);

  localparam int NSLOT = NPHYS + NVIRT;
  localparam int SW    = rpsel_pkg::SEL_W;

  typedef struct packed {
    logic [NSLOT-1:0][SW-1:0] sel;
    logic [NPHYS-1:0]         ansel;
    logic [NPHYS-1:0]         dir;
    logic [NPHYS-1:0]         lat;
    logic [NPHYS-1:0]         pin;
    logic [NPHYS-1:0]         oe;
    logic [NVIRT-1:0]         virt;
    logic                     aw_got;
    logic [7:0]               awaddr;
    logic                     w_got;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
  } rpsel_state_t;

  rpsel_state_t s;
  rpsel_state_t next_s;

  logic [63:0]      src;
  logic [63:0]      asg;
  logic [NSLOT-1:0] rm_act;
  logic [NSLOT-1:0] rm_val;

  // Source table indexed by selector code
  always_comb begin
    src = '0;
    asg = '0;
    for (int k = 0; k < 3; k++) begin
      src[rpsel_pkg::CODE_U1TX + 6'(2 * k)] = 1'b0;
    end
    src[rpsel_pkg::CODE_U1TX] = uart_tx_i[0];
    src[rpsel_pkg::CODE_U2TX] = uart_tx_i[1];
    src[rpsel_pkg::CODE_U3TX] = uart_tx_i[2];
    src[rpsel_pkg::CODE_U1RTS] = uart_rts_i[0];
    src[rpsel_pkg::CODE_U2RTS] = uart_rts_i[1];
    src[rpsel_pkg::CODE_U3RTS] = uart_rts_i[2];
    src[rpsel_pkg::CODE_SPI1]        = spi_sdo_i[0];
    src[rpsel_pkg::CODE_SPI1 + 6'h1] = spi_sck_i[0];
    src[rpsel_pkg::CODE_SPI1 + 6'h2] = spi_ss_i[0];
    src[rpsel_pkg::CODE_SPI2]        = spi_sdo_i[1];
    src[rpsel_pkg::CODE_SPI2 + 6'h1] = spi_sck_i[1];
    src[rpsel_pkg::CODE_SPI2 + 6'h2] = spi_ss_i[1];
    src[rpsel_pkg::CODE_SPI3]        = spi_sdo_i[2];
    src[rpsel_pkg::CODE_SPI3 + 6'h1] = spi_sck_i[2];
    src[rpsel_pkg::CODE_SPI3 + 6'h2] = spi_ss_i[2];
    src[rpsel_pkg::CODE_REFCLK] = reference_clock_out_i;
    for (int k = 0; k < 6; k++) begin
      src[rpsel_pkg::CODE_SCCP1 + 6'(k)] = single_capture_compare_i[k];
    end
    src[rpsel_pkg::CODE_SCCP7]        = single_capture_compare_i[6];
    src[rpsel_pkg::CODE_SCCP7 + 6'h1] = single_capture_compare_i[7];
    src[rpsel_pkg::CODE_CAN] = can_tx_i;
    for (int k = 0; k < 3; k++) begin
      src[rpsel_pkg::CODE_CMP1 + 6'(k)] = comparator_i[k];
    end
    src[rpsel_pkg::CODE_PWM4H] = pwm4_high_i;
    src[rpsel_pkg::CODE_PWM4L] = pwm4_low_i;
    src[rpsel_pkg::CODE_PWM_EVENT_A_OUT]        = pwm_event_i[0];
    src[rpsel_pkg::CODE_PWM_EVENT_A_OUT + 6'h1] = pwm_event_i[1];
    src[rpsel_pkg::CODE_PWMEC]        = pwm_event_i[2];
    src[rpsel_pkg::CODE_PWMEC + 6'h1] = pwm_event_i[3];
    src[rpsel_pkg::CODE_QEI1]        = quadrature_encoder_cmp_i[0];
    src[rpsel_pkg::CODE_QEI1 + 6'h1] = quadrature_encoder_cmp_i[1];
    src[rpsel_pkg::CODE_CLC1]        = configurable_logic_cell_i[0];
    src[rpsel_pkg::CODE_CLC1 + 6'h1] = configurable_logic_cell_i[1];
    src[rpsel_pkg::CODE_CLC3]        = configurable_logic_cell_i[2];
    src[rpsel_pkg::CODE_CLC3 + 6'h1] = configurable_logic_cell_i[3];
    src[rpsel_pkg::CODE_PTG24]        = peripheral_trigger_i[0];
    src[rpsel_pkg::CODE_PTG24 + 6'h1] = peripheral_trigger_i[1];
    src[rpsel_pkg::CODE_SENT1]        = single_edge_nibble_i[0];
    src[rpsel_pkg::CODE_SENT1 + 6'h1] = single_edge_nibble_i[1];
    for (int k = 0; k < 6; k++) begin
      src[rpsel_pkg::CODE_MULTI_CAPTURE_COMPARE_A + 6'(k)] = multi_capture_compare_i[k];
    end
    for (int k = 0; k < 3; k++) begin
      src[rpsel_pkg::CODE_U1DTR + 6'(k)] = uart_dtr_i[k];
    end
    asg[rpsel_pkg::CODE_U1TX  +: 21] = '1;
    asg[rpsel_pkg::CODE_CMP1  +: 3]  = '1;
    asg[rpsel_pkg::CODE_U3TX  +: 2]  = '1;
    asg[rpsel_pkg::CODE_PWM4H +: 22] = '1;
    asg[rpsel_pkg::CODE_CLC3  +: 5]  = '1;
    // zero code is the default port
    asg[rpsel_pkg::CODE_DEFAULT] = 1'b0;
  end

  // Per slot selection
  for (genvar g = 0; g < NSLOT; g++) begin : g_slot
    assign rm_act[g] = asg[s.sel[g]];
    assign rm_val[g] = src[s.sel[g]] & asg[s.sel[g]];
  end

  logic        wr_fire;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_word;
  logic [31:0] wmask;
  logic [31:0] ctrl_word;
  logic [3:0]  rd_idx;

  assign wmask = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}},
                  {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
  assign wr_fire = s.aw_got && s.w_got && !s.bvalid;
  assign rd_idx  = s_axi_araddr_i[5:2];

  always_comb begin
    ctrl_word = '0;
    ctrl_word[rpsel_pkg::ANSEL_POS +: NPHYS] = s.ansel;
    ctrl_word[rpsel_pkg::DIR_POS   +: NPHYS] = s.dir;
    ctrl_word[rpsel_pkg::LAT_POS   +: NPHYS] = s.lat;
  end

  // Read decode
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    if (s_axi_araddr_i[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end else if (s_axi_araddr_i <= rpsel_pkg::ADDR_VIRT_OUT_SEL_26) begin
      rd_word[rpsel_pkg::SEL_LO_POS +: SW] = s.sel[2 * rd_idx];
      rd_word[rpsel_pkg::SEL_HI_POS +: SW] = s.sel[2 * rd_idx + 1];
    end else if (s_axi_araddr_i == rpsel_pkg::ADDR_PORT_CTRL) begin
      rd_word = ctrl_word;
    end else if (s_axi_araddr_i == rpsel_pkg::ADDR_PORT_STATUS) begin
      rd_word[rpsel_pkg::LEVEL_POS +: NPHYS] = pin_i & ~s.ansel;
      rd_word[rpsel_pkg::LATRD_POS +: NPHYS] = s.lat & ~s.ansel;
      rd_word[rpsel_pkg::OE_POS    +: NPHYS] = s.oe;
      rd_word[rpsel_pkg::VIRT_POS  +: NVIRT] = s.virt;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    wr_hit = (s.awaddr[1:0] == 2'h0) &&
             (s.awaddr <= rpsel_pkg::ADDR_PORT_CTRL);
  end

  always_comb begin
    logic [31:0] old_w;
    logic [31:0] new_w;
    logic [3:0]  widx;
    old_w  = '0;
    new_w  = '0;
    widx   = s.awaddr[5:2];
    next_s = s;
    // Address and data may arrive in either order
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata_i;
      next_s.wstrb = s_axi_wstrb_i;
    end
    if (wr_fire) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = wr_hit ? rpsel_pkg::RESP_OKAY
                             : rpsel_pkg::RESP_SLVERR;
      if (wr_hit && s.awaddr == rpsel_pkg::ADDR_PORT_CTRL) begin
        old_w = ctrl_word;
        new_w = (old_w & ~wmask) | (s.wdata & wmask);
        next_s.ansel = new_w[rpsel_pkg::ANSEL_POS +: NPHYS];
        next_s.dir   = new_w[rpsel_pkg::DIR_POS   +: NPHYS];
        next_s.lat   = new_w[rpsel_pkg::LAT_POS   +: NPHYS];
      end else if (wr_hit) begin
        old_w[rpsel_pkg::SEL_LO_POS +: SW] = s.sel[2 * widx];
        old_w[rpsel_pkg::SEL_HI_POS +: SW] = s.sel[2 * widx + 1];
        new_w = (old_w & ~wmask) | (s.wdata & wmask);
        next_s.sel[2 * widx]     = new_w[rpsel_pkg::SEL_LO_POS +: SW];
        next_s.sel[2 * widx + 1] = new_w[rpsel_pkg::SEL_HI_POS +: SW];
      end
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_word;
      next_s.rresp  = rd_hit ? rpsel_pkg::RESP_OKAY
                             : rpsel_pkg::RESP_SLVERR;
    end else if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end
    // Pin drive, highest priority first
    for (int p = 0; p < NPHYS; p++) begin
      if (ded_hi_en_i[p]) begin
        next_s.pin[p] = 1'b0;
        next_s.oe[p]  = 1'b0;
      end else if (ded_out_en_i[p]) begin
        next_s.pin[p] = ded_out_i[p];
        next_s.oe[p]  = 1'b1;
      end else if (rm_act[p]) begin
        next_s.pin[p] = rm_val[p];
        next_s.oe[p]  = 1'b1;
      end else begin
        next_s.pin[p] = s.lat[p];
        next_s.oe[p]  = ~s.dir[p];
      end
    end
    next_s.virt = rm_val[NSLOT-1:NPHYS];
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s        <= '0;
      s.sel    <= {NSLOT{rpsel_pkg::SEL_RESET}};
      s.ansel  <= rpsel_pkg::ANSEL_RESET;
      s.dir    <= rpsel_pkg::DIR_RESET;
      s.lat    <= rpsel_pkg::LAT_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready_o = !s.aw_got && !s.bvalid;
  assign s_axi_wready_o  = !s.w_got && !s.bvalid;
  assign s_axi_bvalid_o  = s.bvalid;
  assign s_axi_bresp_o   = s.bresp;
  assign s_axi_arready_o = !s.rvalid;
  assign s_axi_rvalid_o  = s.rvalid;
  assign s_axi_rdata_o   = s.rdata;
  assign s_axi_rresp_o   = s.rresp;

  assign pin_o                 = s.pin;
  assign pin_oe_o              = s.oe;
  assign pin_digin_en_o        = ~s.ansel;
  assign virtual_route_point_o = s.virt;

endmodule : rpsel_top
`default_nettype wire
